// >>> bench/dmx_exec_asserts.sv
module dmx_exec_asserts
  import dmx_pkg::*;
(
  input wire logic        clock_i,
  input wire logic        reset_i,
  input wire logic [15:0] instr_i,
  input wire logic        instr_valid_i,
  input wire logic        ext_enable_i,
  input wire logic [11:0] mem_addr_o,
  input wire logic        mem_rd_o,
  input wire logic        mem_wr_o,
  input wire logic [7:0]  mem_wdata_o,
  input wire logic [7:0]  acc_o,
  input wire logic [7:0]  bank_select_reg_o,
  input wire logic        flag_we_o,
  input wire logic        second_word_o,
  input wire dmx_phase_t  phase_o
);
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (reset_i);
  logic tk;
  logic cp;
  assign tk = phase_o == DMX_Q1 && instr_valid_i && !second_word_o;
  assign cp = tk && instr_i[15:10] == DMX_COPY_FILE_CODE;
  sequence s_q234;
    phase_o == DMX_Q2 ##1 phase_o == DMX_Q3 ##1 phase_o == DMX_Q4;
  endsequence
  sequence s_dst_wr;
    !mem_rd_o && mem_addr_o == $past(instr_i[11:0]) ##2 mem_wr_o;
  endsequence
  a_phase_ring: assert property (phase_o == DMX_Q1 |=> s_q234)
    else $error("phase sequence broken");
  a_rd_q2: assert property (mem_rd_o |-> phase_o == DMX_Q2)
    else $error("read outside Q2");
  a_wr_q4: assert property (mem_wr_o |-> phase_o == DMX_Q4)
    else $error("write outside Q4");
  a_bank_upper: assert property (bank_select_reg_o[7:4] == 4'h0)
    else $error("bank upper nibble set");
  a_lit_acc: assert property (tk && instr_i[15:8] == DMX_LIT_TO_ACC_CODE
    |-> ##4 acc_o == $past(instr_i[7:0], 4)) else $error("literal load");
  a_bank_load: assert property (tk && instr_i[15:8] == DMX_BANK_LOAD_CODE
    |-> ##4 bank_select_reg_o == {4'h0, $past(instr_i[3:0], 4)})
    else $error("bank load");
  a_store_wr: assert property (tk && instr_i[15:9] == DMX_ACC_TO_FILE_CODE
    |-> ##3 mem_wr_o && mem_wdata_o == acc_o) else $error("store");
  a_copy_bank: assert property (cp && instr_i[8]
    && bank_select_reg_o[3:0] != 4'hf |-> ##1 mem_rd_o
    && mem_addr_o == {bank_select_reg_o[3:0], $past(instr_i[7:0])})
    else $error("banked address");
  a_copy_access: assert property (cp && !instr_i[8] && !ext_enable_i
    && !instr_i[7] |-> ##1 mem_addr_o == {4'h0, $past(instr_i[7:0])})
    else $error("access address");
  a_copy_dest: assert property (cp
    |-> ##3 mem_wr_o == $past(instr_i[9], 3)) else $error("copy dest");
  a_move_src: assert property (tk && instr_i[15:12] == DMX_MOVE_SRC_CODE
    && instr_i[11:0] != DMX_ACC_ADDR |-> ##1 mem_rd_o
    && mem_addr_o == $past(instr_i[11:0]) ##3 second_word_o)
    else $error("move source");
  a_move_dst: assert property (second_word_o && phase_o == DMX_Q1
    && instr_valid_i && instr_i[15:12] == DMX_MOVE_DST_CODE
    && instr_i[11:0] != DMX_ACC_ADDR |-> ##1 s_dst_wr ##1 !flag_we_o)
    else $error("move destination");
endmodule
bind dmx_exec dmx_exec_asserts dmx_exec_asserts_i (.*);

// >>> bench/dmx_exec_tb.sv
module dmx_exec_tb;
  import dmx_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [15:0] w;
    logic [7:0]  acc;
    logic [7:0]  bank;
    logic [11:0] a;
    logic [7:0]  d;
  } dmx_row_t;
  logic        clock_i = 0;
  logic        reset_i = 1;
  logic [15:0] instr_i = 16'h0000;
  logic        instr_valid_i = 0;
  logic        ext_enable_i = 0;
  logic [11:0] index_base_i = 12'h000;
  logic [7:0]  rdata;
  logic [11:0] addr;
  logic        rd;
  logic        wr;
  logic [7:0]  wdata;
  logic [7:0]  acc_o;
  logic [7:0]  bank_select_reg_o;
  logic        second_word_o;
  logic        flag_we_o;
  logic        flag_zero_o;
  logic        flag_neg_o;
  dmx_phase_t  phase_o;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  dmx_row_t    rows [8] = '{
    '{16'h01f5, 8'h00, 8'h05, 12'h000, 8'h00},
    '{16'h0e3c, 8'h3c, 8'h05, 12'h000, 8'h00},
    '{16'h6f10, 8'h3c, 8'h05, 12'h510, 8'h3c},
    '{16'h6e80, 8'h3c, 8'h05, 12'hf80, 8'h3c},
    '{16'h6e20, 8'h3c, 8'h05, 12'h020, 8'h3c},
    '{16'h5133, 8'h33, 8'h05, 12'h533, 8'h33},
    '{16'h5290, 8'h33, 8'h05, 12'hf90, 8'h90},
    '{16'h010a, 8'h33, 8'h0a, 12'h000, 8'h00}
  };
  always #20 clock_i = ~clock_i;
  dmx_exec dmx_exec_i (.clock_i(clock_i), .reset_i(reset_i),
    .instr_i(instr_i), .instr_valid_i(instr_valid_i),
    .ext_enable_i(ext_enable_i), .index_base_i(index_base_i),
    .mem_rdata_i(rdata), .mem_addr_o(addr), .mem_rd_o(rd),
    .mem_wr_o(wr), .mem_wdata_o(wdata), .acc_o(acc_o),
    .bank_select_reg_o(bank_select_reg_o), .flag_we_o(flag_we_o),
    .flag_zero_o(flag_zero_o), .flag_neg_o(flag_neg_o),
    .second_word_o(second_word_o),
    .phase_o(phase_o));
  dmx_mem_model dmx_mem_model_i (.clock_i(clock_i), .addr_i(addr),
    .rd_i(rd), .wr_i(wr), .wdata_i(wdata), .rdata_o(rdata));
  task chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("FAIL %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask
  // One full instruction cycle
  task step(input logic [15:0] w, input logic v);
    instr_i = w;
    instr_valid_i = v;
    repeat (4) @(negedge clock_i);
  endtask
  task mv(input logic [11:0] s, input logic [11:0] d);
    step({DMX_MOVE_SRC_CODE, s}, 1'b1);
    step({DMX_MOVE_DST_CODE, d}, 1'b1);
  endtask
  task complete_run;
    $display("checked %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      complete_run;
    end
  end
  initial begin
    repeat (10) @(negedge clock_i);
    reset_i = 0;
    foreach (rows[i]) begin
      step(rows[i].w, 1'b1);
      chk8("acc", rows[i].acc, acc_o);
      chk8("bank", rows[i].bank, bank_select_reg_o);
      chk8("mem", rows[i].d, dmx_mem_model_i.mem[rows[i].a]);
    end
    chk8("neg hold", 8'h01, {7'h00, flag_neg_o});
    chk8("zero hold", 8'h00, {7'h00, flag_zero_o});
    chk8("flag we bank", 8'h00, {7'h00, flag_we_o});
    mv(12'h533, 12'h7ab);
    chk8("move", 8'h33, dmx_mem_model_i.mem[12'h7ab]);
    mv(12'hfff, 12'h000);
    chk8("move edge", 8'hff, dmx_mem_model_i.mem[12'h000]);
    mv(12'h0c4, DMX_ACC_ADDR);
    chk8("move to acc", 8'hc4, acc_o);
    mv(DMX_ACC_ADDR, 12'h123);
    chk8("move acc", 8'hc4, dmx_mem_model_i.mem[12'h123]);
    step(16'hc533, 1'b1);
    step(16'h7456, 1'b1);
    chk8("abort", 8'h56, dmx_mem_model_i.mem[12'h456]);
    step(16'h0e99, 1'b0);
    chk8("invalid", 8'hc4, acc_o);
    ext_enable_i = 1;
    index_base_i = 12'h200;
    step(16'h6e05, 1'b1);
    chk8("idx store", 8'hc4, dmx_mem_model_i.mem[12'h205]);
    step(16'h505f, 1'b1);
    chk8("idx top", 8'h5f, acc_o);
    step(16'h5060, 1'b1);
    chk8("idx above", 8'h60, acc_o);
    ext_enable_i = 0;
    reset_i = 1;
    repeat (2) @(negedge clock_i);
    chk8("reset acc", DMX_ACC_RESET, acc_o);
    chk8("reset bank", DMX_BANK_RESET, bank_select_reg_o);
    reset_i = 0;
    step(16'h01ff, 1'b1);
    chk8("bank mask", 8'h0f, bank_select_reg_o);
    step(16'h5100, 1'b1);
    chk8("copy zero acc", 8'h00, acc_o);
    chk8("copy zero", 8'h01, {7'h00, flag_zero_o});
    chk8("copy neg", 8'h00, {7'h00, flag_neg_o});
    chk8("copy flag we", 8'h01, {7'h00, flag_we_o});
    complete_run;
  end
endmodule

// >>> bench/dmx_mem_model.sv
module dmx_mem_model
  import dmx_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic [11:0] addr_i,
  input  wire logic        rd_i,
  input  wire logic        wr_i,
  input  wire logic [7:0]  wdata_i,
  output logic      [7:0]  rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ***********************************************************
  // Data space, every byte starts at its low address byte
  // ***********************************************************
  logic [7:0] mem [4096];
  logic [7:0] last = 8'h00;
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = i[7:0];
    end
  end
  // Idle bus shows inverse of last byte
  assign rdata_o = rd_i ? mem[addr_i] : ~last;
  always @(posedge clock_i) begin
    if (rd_i) begin
      last <= mem[addr_i];
    end
    if (wr_i) begin
      mem[addr_i] <= wdata_i;
    end
  end
endmodule

// >>> src/dmx_exec.sv
// Contract
// - access bit 1 uses bank register
// - access bit 0 uses access bank
// - extended mode, f up to 95, indexed
// - two-word move spans full 12-bit space
// - words 1100/1111, copy byte, no flags
// - move reads first cycle, writes last phase
// - accumulator may be move source or target
// - bank load takes literal, no flags
// - bank register upper nibble stays zero
// - store accumulator to file, no flags
// - destination bit picks accumulator or file
module dmx_exec
  import dmx_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  input  wire logic [15:0] instr_i,
  input  wire logic        instr_valid_i,
  input  wire logic        ext_enable_i,
  input  wire logic [11:0] index_base_i,
  input  wire logic [7:0]  mem_rdata_i,
  output logic      [11:0] mem_addr_o,
  output logic             mem_rd_o,
  output logic             mem_wr_o,
  output logic      [7:0]  mem_wdata_o,
  output logic      [7:0]  acc_o,
  output logic      [7:0]  bank_select_reg_o,
  output logic             flag_we_o,
  output logic             flag_zero_o,
  output logic             flag_neg_o,
  output logic             second_word_o,
  output dmx_phase_t       phase_o
);

  // ***********************************************************
  // State
  // ***********************************************************
  dmx_state_t  state;
  dmx_state_t  next_state;
  dmx_op_t     op;
  dmx_op_t     next_op;
  logic        dest_file;
  logic        next_dest_file;
  logic        src_acc;
  logic        next_src_acc;
  logic [7:0]  literal;
  logic [7:0]  next_literal;
  logic [7:0]  data;
  logic [7:0]  next_data;
  logic [11:0] next_mem_addr;
  logic        next_mem_rd;
  logic        next_mem_wr;
  logic [7:0]  next_mem_wdata;
  logic [7:0]  next_acc;
  logic [7:0]  next_bank;
  logic        next_flag_we;
  logic        next_flag_zero;
  logic        next_flag_neg;
  logic [11:0] file_addr;
  logic [11:0] move_addr;

  // ***********************************************************
  // Phase sequencer and address former
  // ***********************************************************
  dmx_phase_gen u_phase (
    .clock_i (clock_i),
    .reset_i (reset_i),
    .phase_o (phase_o)
  );

  dmx_file_addr u_addr (
    .file_i       (instr_i[7:0]),
    .access_i     (instr_i[DMX_ACCESS_BIT]),
    .bank_i       (bank_select_reg_o[3:0]),
    .ext_enable_i (ext_enable_i),
    .index_base_i (index_base_i),
    .addr_o       (file_addr)
  );

  assign move_addr = instr_i[11:0];

  // ***********************************************************
  // Next-value logic
  // ***********************************************************
  always_comb begin
    next_state     = state;
    next_op        = op;
    next_dest_file = dest_file;
    next_src_acc   = src_acc;
    next_literal   = literal;
    next_data      = data;
    next_mem_addr  = mem_addr_o;
    next_mem_rd    = mem_rd_o;
    next_mem_wr    = mem_wr_o;
    next_mem_wdata = mem_wdata_o;
    next_acc       = acc_o;
    next_bank      = bank_select_reg_o;
    next_flag_we   = 1'b0;
    next_flag_zero = flag_zero_o;
    next_flag_neg  = flag_neg_o;
    case (phase_o)
      DMX_Q1: begin
        next_mem_wr = 1'b0;
        next_mem_rd = 1'b0;
        if (state == DMX_ST_SECOND) begin
          next_state = DMX_ST_NORMAL;
          if (instr_valid_i && (instr_i[15:12] == DMX_MOVE_DST_CODE)) begin
            next_op       = DMX_OP_MOVE_DST;
            next_mem_addr = move_addr;
          end else begin
            next_op = DMX_OP_NONE;
          end
        end else if (!instr_valid_i) begin
          next_op = DMX_OP_NONE;
        end else if (instr_i[15:10] == DMX_COPY_FILE_CODE) begin
          next_op        = DMX_OP_COPY;
          next_mem_addr  = file_addr;
          next_dest_file = instr_i[DMX_DEST_BIT];
          next_src_acc   = (file_addr == DMX_ACC_ADDR);
          next_mem_rd    = (file_addr != DMX_ACC_ADDR);
        end else if (instr_i[15:9] == DMX_ACC_TO_FILE_CODE) begin
          next_op        = DMX_OP_STORE;
          next_mem_addr  = file_addr;
          next_dest_file = (file_addr != DMX_ACC_ADDR);
        end else if (instr_i[15:12] == DMX_MOVE_SRC_CODE) begin
          next_op       = DMX_OP_MOVE_SRC;
          next_mem_addr = move_addr;
          next_src_acc  = (move_addr == DMX_ACC_ADDR);
          next_mem_rd   = (move_addr != DMX_ACC_ADDR);
        end else if (instr_i[15:8] == DMX_BANK_LOAD_CODE) begin
          next_op      = DMX_OP_BANK;
          next_literal = instr_i[7:0];
        end else if (instr_i[15:8] == DMX_LIT_TO_ACC_CODE) begin
          next_op      = DMX_OP_LIT;
          next_literal = instr_i[7:0];
        end else begin
          next_op = DMX_OP_NONE;
        end
      end
      DMX_Q2: begin
        next_mem_rd = 1'b0;
        if ((op == DMX_OP_COPY) || (op == DMX_OP_MOVE_SRC)) begin
          next_data = src_acc ? acc_o : mem_rdata_i;
        end
      end
      DMX_Q3: begin
        case (op)
          DMX_OP_COPY: begin
            // write back only for bit 1
            if (dest_file && !src_acc) begin
              next_mem_wr    = 1'b1;
              next_mem_wdata = data;
            end
          end
          DMX_OP_STORE: begin
            if (dest_file) begin
              next_mem_wr    = 1'b1;
              next_mem_wdata = acc_o;
            end
          end
          DMX_OP_MOVE_DST: begin
            // write in last phase, no dummy read
            if (mem_addr_o != DMX_ACC_ADDR) begin
              next_mem_wr    = 1'b1;
              next_mem_wdata = data;
            end
          end
          default: begin
            next_mem_wr = 1'b0;
          end
        endcase
      end
      DMX_Q4: begin
        next_mem_wr = 1'b0;
        case (op)
          DMX_OP_COPY: begin
            // bit 0 sends result to accumulator
            if (!dest_file || src_acc) begin
              next_acc = data;
            end
            next_flag_we   = 1'b1;
            next_flag_zero = (data == 8'h00);
            next_flag_neg  = data[7];
          end
          DMX_OP_MOVE_SRC: begin
            next_state = DMX_ST_SECOND;
          end
          DMX_OP_MOVE_DST: begin
            if (mem_addr_o == DMX_ACC_ADDR) begin
              next_acc = data;
            end
          end
          DMX_OP_BANK: begin
            next_bank = {DMX_BANK_UPPER, literal[3:0]};
          end
          DMX_OP_LIT: begin
            next_acc = literal;
          end
          default: begin
            next_acc = acc_o;
          end
        endcase
      end
      default: begin
        next_mem_rd = 1'b0;
        next_mem_wr = 1'b0;
      end
    endcase
  end

  // ***********************************************************
  // Registers
  // ***********************************************************
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state             <= DMX_ST_NORMAL;
      op                <= DMX_OP_NONE;
      dest_file         <= 1'b0;
      src_acc           <= 1'b0;
      literal           <= DMX_DATA_RESET;
      data              <= DMX_DATA_RESET;
      mem_addr_o        <= DMX_ADDR_RESET;
      mem_rd_o          <= 1'b0;
      mem_wr_o          <= 1'b0;
      mem_wdata_o       <= DMX_DATA_RESET;
      acc_o             <= DMX_ACC_RESET;
      bank_select_reg_o <= DMX_BANK_RESET;
      flag_we_o         <= 1'b0;
      flag_zero_o       <= 1'b0;
      flag_neg_o        <= 1'b0;
      second_word_o     <= 1'b0;
    end else begin
      state             <= next_state;
      op                <= next_op;
      dest_file         <= next_dest_file;
      src_acc           <= next_src_acc;
      literal           <= next_literal;
      data              <= next_data;
      mem_addr_o        <= next_mem_addr;
      mem_rd_o          <= next_mem_rd;
      mem_wr_o          <= next_mem_wr;
      mem_wdata_o       <= next_mem_wdata;
      acc_o             <= next_acc;
      bank_select_reg_o <= next_bank;
      flag_we_o         <= next_flag_we;
      flag_zero_o       <= next_flag_zero;
      flag_neg_o        <= next_flag_neg;
      second_word_o     <= (next_state == DMX_ST_SECOND);
    end
  end

endmodule

// >>> src/dmx_file_addr.sv
module dmx_file_addr
  import dmx_pkg::*;
(
  input  wire logic [7:0]  file_i,
  input  wire logic        access_i,
  input  wire logic [3:0]  bank_i,
  input  wire logic        ext_enable_i,
  input  wire logic [11:0] index_base_i,
  output logic      [11:0] addr_o
);

  // ***********************************************************
  // File register address forming
  // ***********************************************************
  always_comb begin
    if (access_i) begin
      addr_o = {bank_i, file_i};
    end else if (ext_enable_i && (file_i <= DMX_INDEXED_MAX)) begin
      addr_o = index_base_i + {4'h0, file_i};
    end else if (file_i < DMX_ACCESS_SPLIT) begin
      addr_o = {DMX_ACCESS_LOBANK, file_i};
    end else begin
      addr_o = {DMX_ACCESS_HIBANK, file_i};
    end
  end

endmodule

// >>> src/dmx_phase_gen.sv
module dmx_phase_gen
  import dmx_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       reset_i,
  output dmx_phase_t      phase_o
);

  dmx_phase_t next_phase;

  // ***********************************************************
  // Four-phase sequencer
  // ***********************************************************
  always_comb begin
    case (phase_o)
      DMX_Q1:  next_phase = DMX_Q2;
      DMX_Q2:  next_phase = DMX_Q3;
      DMX_Q3:  next_phase = DMX_Q4;
      DMX_Q4:  next_phase = DMX_Q1;
      default: next_phase = DMX_Q1;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      phase_o <= DMX_Q1;
    end else begin
      phase_o <= next_phase;
    end
  end

endmodule

// >>> src/dmx_pkg.sv
package dmx_pkg;

  // ***********************************************************
  // Encodings
  // ***********************************************************
  localparam logic [5:0] DMX_COPY_FILE_CODE   = 6'h14;
  localparam logic [6:0] DMX_ACC_TO_FILE_CODE = 7'h37;
  localparam logic [7:0] DMX_BANK_LOAD_CODE   = 8'h01;
  localparam logic [7:0] DMX_LIT_TO_ACC_CODE  = 8'h0e;
  localparam logic [3:0] DMX_MOVE_SRC_CODE    = 4'hc;
  localparam logic [3:0] DMX_MOVE_DST_CODE    = 4'hf;

  // ***********************************************************
  // Field positions
  // ***********************************************************
  localparam int DMX_ACCESS_BIT = 8;
  localparam int DMX_DEST_BIT   = 9;

  // ***********************************************************
  // Address map
  // ***********************************************************
  localparam logic [11:0] DMX_ACC_ADDR      = 12'hfe8;
  localparam logic [7:0]  DMX_ACCESS_SPLIT  = 8'h80;
  localparam logic [3:0]  DMX_ACCESS_HIBANK = 4'hf;
  localparam logic [3:0]  DMX_ACCESS_LOBANK = 4'h0;
  localparam logic [7:0]  DMX_INDEXED_MAX   = 8'h5f;
  localparam logic [3:0]  DMX_BANK_UPPER    = 4'h0;

  // ***********************************************************
  // Reset values
  // ***********************************************************
  localparam logic [7:0]  DMX_ACC_RESET  = 8'h00;
  localparam logic [7:0]  DMX_BANK_RESET = 8'h00;
  localparam logic [11:0] DMX_ADDR_RESET = 12'h000;
  localparam logic [7:0]  DMX_DATA_RESET = 8'h00;

  // ***********************************************************
  // Types
  // ***********************************************************
  typedef enum logic [3:0] {
    DMX_Q1 = 4'b0001,
    DMX_Q2 = 4'b0010,
    DMX_Q3 = 4'b0100,
    DMX_Q4 = 4'b1000
  } dmx_phase_t;

  typedef enum logic [1:0] {
    DMX_ST_NORMAL = 2'b01,
    DMX_ST_SECOND = 2'b10
  } dmx_state_t;

  typedef enum logic [6:0] {
    DMX_OP_NONE     = 7'b0000001,
    DMX_OP_COPY     = 7'b0000010,
    DMX_OP_MOVE_SRC = 7'b0000100,
    DMX_OP_MOVE_DST = 7'b0001000,
    DMX_OP_BANK     = 7'b0010000,
    DMX_OP_LIT      = 7'b0100000,
    DMX_OP_STORE    = 7'b1000000
  } dmx_op_t;

endpackage
